// File: core/eia_core.sv
// Purpose: input energy and elapsed time accumulator with its command registers
// Assumes: a command engine decodes the serial bus and drives the strobes below
// Notes:   ms tick period is a parameter so simulation can shorten it
`timescale 1ns/100ps

module eia_core
#(
   parameter int TICK_CYC = eia_pkg::TICK_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_send,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        wp_level2,
   input  wire logic        rd_start,
   input  wire logic        rd_next,
   input  wire logic        rd_stop,
   output logic      [3:0]  rd_len,
   output logic      [7:0]  rd_data,
   output logic             rd_busy,
   input  wire logic        nv_load,
   input  wire logic [7:0]  nv_config,
   input  wire logic [15:0] nv_tempco,
   input  wire logic [15:0] nv_sense_res,
   output logic      [7:0]  energy_config,
   output logic      [15:0] sense_resistance_tempco,
   output logic      [15:0] sense_resistance_setting,
   input  wire logic [15:0] vin_reading,
   input  wire logic [15:0] iin_reading,
   input  wire logic        adc_update,
   input  wire logic        adc_slot,
   input  wire logic        channel_off,
   input  wire logic [15:0] noise_decrement,
   output logic             high_definition_select,
   output logic             adc_take_vi,
   output logic      [1:0]  current_full_scale,
   output logic             range_high,
   output logic             range_medium,
   output logic             range_low,
   output logic             range_reserved
);
   import eia_pkg::*;

   logic [7:0]         cfg_q;
   logic [15:0]        tempco_q;
   logic [15:0]        sres_q;
   logic [ACC_W-1:0]   e_acc_q;
   logic [VAL_W-1:0]   t_acc_q;
   logic [31:0]        presc_q;
   logic [31:0]        prod_q;
   logic               clr_pend_q;
   logic [VAL_W-1:0]   snap_e_q;
   logic [VAL_W-1:0]   snap_t_q;
   eia_rd_t            rd_st_q;
   logic [3:0]         idx_q;
   logic [7:0]         rd_data_q;
   logic               take_vi_q;

   // decode
   wire logic            wr_cfg      = cmd_wr && !wp_level2 && cmd_code == CMD_ENERGY_CONFIG;
   wire logic            wr_tempco   = cmd_wr && !wp_level2 && cmd_code == CMD_TEMPCO;
   wire logic            wr_sres     = cmd_wr && !wp_level2 && cmd_code == CMD_SENSE_RES;
   // clear ignores write protect so software can always restart a measurement
   wire logic            clr_cmd     = cmd_send && cmd_code == CMD_ENERGY_CLEAR;
   wire logic            clr_req     = wr_cfg || clr_cmd;
   wire logic            clr_apply   = clr_pend_q && adc_update;
   wire logic            tick        = presc_q == 32'(TICK_CYC - 1);
   wire logic [ACC_W-1:0] dec_ext    = ACC_W'(noise_decrement);
   wire logic [ACC_W-1:0] e_add      = e_acc_q + ACC_W'(prod_q);
   wire logic [ACC_W-1:0] e_sub      = (e_acc_q < dec_ext) ? '0 : e_acc_q - dec_ext;
   wire logic [95:0]     blk         = {snap_t_q, snap_e_q};
   wire logic            is_block    = cmd_code == CMD_ENERGY_BLOCK;
   wire logic            is_word     = cmd_code == CMD_TEMPCO || cmd_code == CMD_SENSE_RES;
   wire logic [15:0]     word_sel    = (cmd_code == CMD_TEMPCO) ? tempco_q : sres_q;
   wire logic [7:0]      cfg_rd      = cfg_q & CFG_WRITE_MASK;
   wire logic [7:0]      blk_byte0   = blk[7:0];
   wire logic [3:0]      idx_nxt     = (idx_q == LAST_BLOCK_IDX) ? idx_q : idx_q + 4'h1;

   // the energy block answers reads only; writes to it fall through decode untouched
   assign rd_len = is_block ? LEN_BLOCK :
                   is_word ? LEN_WORD :
                   (cmd_code == CMD_ENERGY_CONFIG) ? LEN_BYTE : LEN_NONE;

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_q    <= CONFIG_RESET;
         tempco_q <= TEMPCO_RESET;
         sres_q   <= SENSE_RES_RESET;
      end else if (ce) begin
         if (nv_load) begin
            cfg_q    <= nv_config & CFG_WRITE_MASK;
            tempco_q <= nv_tempco;
            sres_q   <= nv_sense_res;
         end else begin
            if (wr_cfg)
               cfg_q <= cmd_wdata[7:0] & CFG_WRITE_MASK;
            if (wr_tempco)
               tempco_q <= cmd_wdata;
            if (wr_sres)
               sres_q <= cmd_wdata;
         end
      end
   end

   // clear pending; a new request in the apply cycle stays pending
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         clr_pend_q <= 1'b0;
      else if (ce)
         clr_pend_q <= (clr_pend_q && !adc_update) || clr_req;
   end

   // latest reading product, taken per adc update
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         prod_q <= 32'h0000_0000;
      else if (ce && adc_update)
         prod_q <= vin_reading * iin_reading;
   end

   // accumulators; product is in 2^-16 mJ per ms so the integer part counts mJ
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         e_acc_q <= '0;
         t_acc_q <= '0;
         presc_q <= 32'h0000_0000;
      end else if (ce) begin
         if (clr_apply) begin
            e_acc_q <= '0;
            t_acc_q <= '0;
            presc_q <= 32'h0000_0000;
         end else begin
            presc_q <= tick ? 32'h0000_0000 : presc_q + 32'h0000_0001;
            if (tick) begin
               e_acc_q <= channel_off ? e_sub : e_add;
               t_acc_q <= t_acc_q + 48'h0000_0000_0001;
            end
         end
      end
   end

   // snapshot follows the accumulators except while a block read runs
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         snap_e_q <= '0;
         snap_t_q <= '0;
      end else if (ce && rd_st_q != RD_BLOCK && !(rd_start && is_block)) begin
         snap_e_q <= e_acc_q[ACC_W-1:FRAC_W];
         snap_t_q <= t_acc_q;
      end
   end

   // read sequencer
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_st_q   <= RD_IDLE;
         idx_q     <= 4'h0;
         rd_data_q <= 8'h00;
      end else if (ce) begin
         case (rd_st_q)
            RD_IDLE: begin
               if (rd_start) begin
                  idx_q <= 4'h0;
                  if (is_block) begin
                     rd_st_q   <= RD_BLOCK;
                     rd_data_q <= blk_byte0;
                  end else if (is_word) begin
                     rd_st_q   <= RD_WORD;
                     rd_data_q <= word_sel[7:0];
                  end else if (cmd_code == CMD_ENERGY_CONFIG) begin
                     rd_st_q   <= RD_BYTE;
                     rd_data_q <= cfg_rd;
                  end else begin
                     rd_data_q <= 8'h00;
                  end
               end
            end
            RD_BLOCK: begin
               if (rd_stop)
                  rd_st_q <= RD_IDLE;
               else if (rd_next) begin
                  idx_q     <= idx_nxt;
                  rd_data_q <= blk[8*idx_nxt +: 8];
               end
            end
            RD_WORD: begin
               if (rd_stop)
                  rd_st_q <= RD_IDLE;
               else if (rd_next)
                  rd_data_q <= word_sel[15:8];
            end
            default: begin
               if (rd_stop)
                  rd_st_q <= RD_IDLE;
            end
         endcase
      end
   end

   // slot scheduler: in hd mode every other adc slot goes to voltage/current
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         take_vi_q <= 1'b0;
      else if (ce && adc_slot)
         take_vi_q <= cfg_q[CFG_HD_BIT] ? !take_vi_q : 1'b0;
   end

   assign rd_data                  = rd_data_q;
   assign rd_busy                  = rd_st_q != RD_IDLE;
   assign energy_config            = cfg_rd;
   assign sense_resistance_tempco  = tempco_q;
   assign sense_resistance_setting = sres_q;
   assign high_definition_select   = cfg_q[CFG_HD_BIT];
   assign adc_take_vi              = take_vi_q;
   assign current_full_scale       = cfg_q[CFG_RANGE_LSB +: 2];
   assign range_high               = current_full_scale == RANGE_HIGH;
   assign range_medium             = current_full_scale == RANGE_MEDIUM;
   assign range_low                = current_full_scale == RANGE_LOW;
   assign range_reserved           = &current_full_scale;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_clear_zeroes: assert property (ce && clr_apply |=> e_acc_q == '0 && t_acc_q == '0)
      else $error("clear did not zero accumulators");
   chk_time_step: assert property (ce && tick && !clr_apply |=> t_acc_q == $past(t_acc_q) + 48'h1)
      else $error("time counter missed a tick");
   chk_time_wrap: assert property (ce && tick && !clr_apply && &t_acc_q |=> t_acc_q == '0)
      else $error("time counter saturated");
   chk_energy_clamp: assert property (ce && tick && !clr_apply && channel_off && e_acc_q < dec_ext
                                      |=> e_acc_q == '0)
      else $error("energy went below zero");
   chk_snap_frozen: assert property (ce && rd_st_q == RD_BLOCK |=> $stable(snap_e_q) && $stable(snap_t_q))
      else $error("snapshot moved during block read");
   chk_snap_pair: assert property (ce && rd_st_q == RD_IDLE && !rd_start
                                   |=> snap_t_q == $past(t_acc_q) && snap_e_q == $past(e_acc_q[ACC_W-1:FRAC_W]))
      else $error("snapshot halves out of step");
   chk_block_byte0: assert property (ce && rd_st_q == RD_IDLE && rd_start && is_block
                                     |=> rd_data == $past(snap_e_q[7:0]) && rd_busy)
      else $error("first block byte wrong");
   chk_cfg_upper: assert property (energy_config[7:3] == 5'h00)
      else $error("reserved config bits nonzero");
   chk_clear_wp: assert property (ce && clr_cmd |=> clr_pend_q)
      else $error("clear command dropped");
   chk_hd_alt: assert property (ce && adc_slot && cfg_q[CFG_HD_BIT] |=> adc_take_vi != $past(adc_take_vi))
      else $error("hd slot did not alternate");
   // a clear waits for an adc update so a product in flight is never split
   chk_clear_waits: assert property (ce && clr_pend_q && !adc_update && !clr_req |=> clr_pend_q)
      else $error("pending clear lost before adc update");
   chk_energy_add: assert property (ce && tick && !clr_apply && !channel_off
                                    |=> e_acc_q == $past(e_acc_q) + ACC_W'($past(prod_q)))
      else $error("energy did not add the product");
   // energy and time only move together, on a tick or on an applied clear, which keeps the pair coherent
   chk_energy_hold: assert property (ce && !tick && !clr_apply |=> $stable(e_acc_q) && $stable(t_acc_q))
      else $error("accumulators moved between ticks");
   chk_range_onehot: assert property ($onehot({range_high, range_medium, range_low, range_reserved}))
      else $error("range decode not one-hot");
   chk_block_len: assert property (is_block |-> rd_len == LEN_BLOCK)
      else $error("energy block length not twelve");
   chk_block_last: assert property (ce && rd_st_q == RD_BLOCK && rd_next && !rd_stop && idx_q == 4'hA
                                    |=> rd_data == $past(snap_t_q[47:40]))
      else $error("last block byte not time high byte");
   chk_unknown_read: assert property (ce && rd_st_q == RD_IDLE && rd_start && rd_len == LEN_NONE
                                      |=> rd_data == 8'h00 && !rd_busy)
      else $error("unknown command started a read");
   // write protect is a local choice; the clear path bypasses it on purpose
   chk_wp_guard: assert property (ce && wp_level2 && !nv_load
                                  |=> $stable(cfg_q) && $stable(tempco_q) && $stable(sres_q))
      else $error("register written under write protect");
   chk_hd_off: assert property (ce && adc_slot && !cfg_q[CFG_HD_BIT] |=> !adc_take_vi)
      else $error("standard order took a vi slot");
   chk_cfg_write: assert property (ce && wr_cfg && !nv_load
                                   |=> energy_config == ($past(cmd_wdata[7:0]) & CFG_WRITE_MASK))
      else $error("config write not masked");
   chk_word_high: assert property (ce && rd_st_q == RD_WORD && rd_next && !rd_stop
                                   |=> rd_data == $past(word_sel[15:8]))
      else $error("word read high byte wrong");

   cov_block_read: cover property (rd_st_q == RD_BLOCK && rd_next ##2 rd_next ##2 rd_next);
   cov_clear_during_read: cover property (rd_st_q == RD_BLOCK && clr_apply);
   cov_decrement: cover property (tick && channel_off && e_acc_q != '0);
   cov_time_wrap: cover property (tick && &t_acc_q);
   cov_hd_slot: cover property (adc_slot && high_definition_select ##1 adc_take_vi);
endmodule

// File: include/eia_pkg.sv
// Purpose: constants for the input energy accumulator
// Assumes: 100 MHz system clock
// Notes:   command codes double as register offsets
package eia_pkg;
   localparam logic [7:0]  CMD_ENERGY_BLOCK  = 8'hC0;
   localparam logic [7:0]  CMD_ENERGY_CONFIG = 8'hC1;
   localparam logic [7:0]  CMD_TEMPCO        = 8'hC3;
   localparam logic [7:0]  CMD_ENERGY_CLEAR  = 8'hCC;
   localparam logic [7:0]  CMD_SENSE_RES     = 8'hE8;
   localparam logic [7:0]  CONFIG_RESET      = 8'h00;
   localparam logic [15:0] TEMPCO_RESET      = 16'h0000;
   localparam logic [15:0] SENSE_RES_RESET   = 16'hBA00;
   localparam int          CFG_HD_BIT        = 2;
   localparam int          CFG_RANGE_LSB     = 0;
   localparam logic [7:0]  CFG_WRITE_MASK    = 8'h07;
   localparam logic [1:0]  RANGE_HIGH        = 2'h0;
   localparam logic [1:0]  RANGE_MEDIUM      = 2'h1;
   localparam logic [1:0]  RANGE_LOW         = 2'h2;
   localparam int          VAL_W             = 48;
   localparam int          FRAC_W            = 16;
   localparam int          ACC_W             = VAL_W + FRAC_W;
   localparam logic [3:0]  LEN_BLOCK         = 4'hC;
   localparam logic [3:0]  LEN_WORD          = 4'h2;
   localparam logic [3:0]  LEN_BYTE          = 4'h1;
   localparam logic [3:0]  LEN_NONE          = 4'h0;
   localparam logic [3:0]  LAST_BLOCK_IDX    = 4'hB;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          TICK_NS           = 1000000;
   localparam int          TICK_CYCLES       = TICK_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_BLOCK = 2'b01,
      RD_WORD  = 2'b10,
      RD_BYTE  = 2'b11
   } eia_rd_t;
endpackage

// File: tb/eia_host.sv
// Purpose: host command engine model for the energy block
// Assumes: one-cycle strobes, driven just after a clk_sys rising edge
// Notes:   cmd_code is held for the whole read, since rd_len decodes from it
`timescale 1ns/100ps
module eia_host (
   input  wire logic       clk_sys,
   input  wire logic [7:0] rd_data,
   output logic            cmd_wr,
   output logic            cmd_send,
   output logic [7:0]      cmd_code,
   output logic [15:0]     cmd_wdata,
   output logic            rd_start,
   output logic            rd_next,
   output logic            rd_stop
);
   logic [7:0] q [12];
   initial begin
      cmd_wr = 1'b0;
      cmd_send = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      rd_start = 1'b0;
      rd_next = 1'b0;
      rd_stop = 1'b0;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic send);
      @(posedge clk_sys);
      cmd_code <= c;
      cmd_wdata <= d;
      cmd_wr <= ~send;
      cmd_send <= send;
      @(posedge clk_sys);
      cmd_wr <= 1'b0;
      cmd_send <= 1'b0;
   endtask
   // gap stalls between byte 5 and 6, the worst place for a torn snapshot
   task automatic rd(input logic [7:0] c, input int n, input int gap);
      @(posedge clk_sys);
      cmd_code <= c;
      rd_start <= 1'b1;
      @(posedge clk_sys);
      rd_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         #1 q[i] = rd_data;
         repeat ((i == 5) ? gap : 0) @(posedge clk_sys);
         @(posedge clk_sys);
         rd_next <= (i < n - 1);
         rd_stop <= (i == n - 1);
         @(posedge clk_sys);
         rd_next <= 1'b0;
         rd_stop <= 1'b0;
      end
   endtask
endmodule

// File: tb/eia_core_tb.sv
// Purpose: self-checking bench for eia_core
// Assumes: ms tick shortened to TICK cycles; vin*iin of 0x10000 is 1 mJ per tick
// Notes:   48-bit wrap is out of reach in simulation time
`timescale 1ns/100ps
module eia_core_tb;
   import eia_pkg::*;
   localparam int TICK = 20;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic wp_level2 = 1'b0;
   logic adc_update = 1'b0;
   logic adc_slot = 1'b0;
   logic channel_off = 1'b0;
   logic [15:0] noise_decrement = 16'h0000;
   logic cmd_wr, cmd_send, rd_start, rd_next, rd_stop, rd_busy, hd, take_vi;
   logic [7:0] cmd_code, rd_data;
   logic [15:0] cmd_wdata;
   logic [1:0] fs;
   logic [3:0] rng;
   logic [47:0] e, t, t0;
   logic [15:0] vin = 16'h0100;
   logic [15:0] iin = 16'h0100;
   logic [3:0] len;
   logic [7:0] cfg_o;
   logic [15:0] tc_o, sr_o;
   int busy_cyc = 0;
   int failures = 0;
   int checks_done = 0;
   always #5 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
      if (rd_busy === 1'b1) busy_cyc++;
   eia_host host (.clk_sys(clk_sys), .rd_data(rd_data), .cmd_wr(cmd_wr), .cmd_send(cmd_send),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_start(rd_start), .rd_next(rd_next), .rd_stop(rd_stop));
   eia_core #(.TICK_CYC(TICK)) dut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .cmd_wr(cmd_wr),
      .cmd_send(cmd_send), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .wp_level2(wp_level2),
      .rd_start(rd_start), .rd_next(rd_next), .rd_stop(rd_stop), .rd_len(len), .rd_data(rd_data),
      .rd_busy(rd_busy), .nv_load(1'b0), .nv_config(8'h00), .nv_tempco(16'h0000),
      .nv_sense_res(16'h0000), .energy_config(cfg_o), .sense_resistance_tempco(tc_o),
      .sense_resistance_setting(sr_o),
      .vin_reading(vin), .iin_reading(iin), .adc_update(adc_update), .adc_slot(adc_slot),
      .channel_off(channel_off), .noise_decrement(noise_decrement), .high_definition_select(hd),
      .adc_take_vi(take_vi), .current_full_scale(fs), .range_high(rng[0]), .range_medium(rng[1]),
      .range_low(rng[2]), .range_reserved(rng[3]));
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic pulse_adc(input logic slot);
      @(posedge clk_sys);
      if (slot) adc_slot <= 1'b1; else adc_update <= 1'b1;
      @(posedge clk_sys);
      adc_slot <= 1'b0;
      adc_update <= 1'b0;
      #1;
   endtask
   task automatic rd_ein(input int gap);
      host.rd(CMD_ENERGY_BLOCK, 12, gap);
      e = {host.q[5], host.q[4], host.q[3], host.q[2], host.q[1], host.q[0]};
      t = {host.q[11], host.q[10], host.q[9], host.q[8], host.q[7], host.q[6]};
   endtask
   task automatic t_reset();
      chk(rd_busy, 1'b0);
      chk(rng, 48'h1);
      chk(sr_o, SENSE_RES_RESET);
      host.rd(CMD_ENERGY_CONFIG, 1, 0);
      chk(host.q[0], CONFIG_RESET);
      host.rd(CMD_TEMPCO, 2, 0);
      chk({host.q[1], host.q[0]}, TEMPCO_RESET);
      host.rd(CMD_SENSE_RES, 2, 0);
      chk({host.q[1], host.q[0]}, SENSE_RES_RESET);
   endtask
   task automatic t_config();
      host.wr(CMD_ENERGY_CONFIG, 16'h00FF, 1'b0);
      host.rd(CMD_ENERGY_CONFIG, 1, 0);
      chk(host.q[0], 48'h07);
      chk(cfg_o, 48'h07);
      chk(len, LEN_BYTE);
      for (int r = 0; r < 4; r++) begin
         host.wr(CMD_ENERGY_CONFIG, 16'(r), 1'b0);
         repeat (2) @(posedge clk_sys);
         #1;
         chk(fs, 48'(r));
         chk(rng, 48'(1 << r));
      end
   endtask
   task automatic t_hd();
      host.wr(CMD_ENERGY_CONFIG, 16'h0004, 1'b0);
      pulse_adc(1'b1);
      chk(take_vi, 48'h1);
      chk(hd, 48'h1);
      pulse_adc(1'b1);
      chk(take_vi, 48'h0);
      host.wr(CMD_ENERGY_CONFIG, 16'h0000, 1'b0);
      pulse_adc(1'b1);
      chk(take_vi, 48'h0);
      chk(hd, 48'h0);
   endtask
   task automatic t_accum();
      host.wr(CMD_ENERGY_CLEAR, 16'h0000, 1'b1);
      pulse_adc(1'b0);
      repeat (6 * TICK) @(posedge clk_sys);
      rd_ein(3 * TICK);
      chk(e, t);
      chk(48'(t >= 6 && t <= 7), 48'h1);
      chk(48'(e != 0), 48'h1);
      t0 = t;
      busy_cyc = 0;
      rd_ein(0);
      chk(48'(t >= t0 + 3), 48'h1);
      chk(busy_cyc, 48'h18);
      chk(len, LEN_BLOCK);
   endtask
   task automatic t_wp();
      wp_level2 <= 1'b1;
      host.wr(CMD_TEMPCO, 16'h1234, 1'b0);
      host.rd(CMD_TEMPCO, 2, 0);
      chk({host.q[1], host.q[0]}, TEMPCO_RESET);
      host.wr(CMD_ENERGY_CLEAR, 16'h0000, 1'b1);
      pulse_adc(1'b0);
      rd_ein(0);
      chk(48'(e < 2 && t < 2), 48'h1);
      wp_level2 <= 1'b0;
      host.wr(CMD_SENSE_RES, 16'h1234, 1'b0);
      host.rd(CMD_SENSE_RES, 2, 0);
      chk({host.q[1], host.q[0]}, 48'h1234);
      chk(sr_o, 48'h1234);
      host.wr(CMD_TEMPCO, 16'h2A5C, 1'b0);
      host.rd(CMD_TEMPCO, 2, 0);
      chk({host.q[1], host.q[0]}, 48'h2A5C);
      chk(tc_o, 48'h2A5C);
      host.rd(CMD_ENERGY_CLEAR, 1, 0);
      chk(host.q[0], 48'h00);
      chk(len, LEN_NONE);
   endtask
   task automatic t_off();
      vin <= 16'h0080;
      host.wr(CMD_ENERGY_CONFIG, 16'h0000, 1'b0);
      pulse_adc(1'b0);
      repeat (5 * TICK) @(posedge clk_sys);
      rd_ein(0);
      chk(e, 48'h2);
      chk(t, 48'h5);
      channel_off <= 1'b1;
      noise_decrement <= 16'hFFFF;
      repeat (10 * TICK) @(posedge clk_sys);
      rd_ein(0);
      chk(e, 48'h0);
      chk(48'(t >= 14), 48'h1);
      channel_off <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_config();
      t_hd();
      t_accum();
      t_wp();
      t_off();
      tally_and_finish();
   end
   // hang guard: the whole run is under a thousand cycles
   initial begin
      #500000;
      failures++;
      tally_and_finish();
   end
endmodule
